/* File: rtl/rsp_consts.vh */
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH

// apb register byte offsets
`define RSP_OFS_CTRL 8'h00
`define RSP_OFS_SP_HIGH 8'h04
`define RSP_OFS_SP_LOW 8'h08
`define RSP_OFS_RSP_HIGH 8'h0c
`define RSP_OFS_RSP_LOW 8'h10
`define RSP_OFS_LOCAL_SP 8'h14
`define RSP_OFS_REMOTE_SP 8'h18
`define RSP_OFS_ACTIVE_SP 8'h1c
`define RSP_OFS_LOOP_IN 8'h20
`define RSP_OFS_IRQ_STAT 8'h24
`define RSP_OFS_IRQ_MASK 8'h28
`define RSP_OFS_ALARM 8'h2c

// control register fields
`define RSP_CTRL_ALLOW 0
`define RSP_CTRL_FOLLOW 1
`define RSP_CTRL_FAULT_OUT 2
`define RSP_CTRL_SELF_TUNE 3
`define RSP_CTRL_REMOTE_MODE 4
`define RSP_CTRL_ALM1_WORK_BIT 5
`define RSP_CTRL_SETTING_LVL 6
`define RSP_CTRL_WIDTH 7
`define RSP_CTRL_RESET 7'h00

// interrupt status fields
`define RSP_IRQ_INPUT_ERR 0
`define RSP_IRQ_TO_LOCAL 1
`define RSP_IRQ_LIMIT_FORCED 2
`define RSP_IRQ_WIDTH 3

// set points in tenths of an engineering unit, 16-bit two's complement
`define RSP_SP_HIGH_RESET 16'h32c8
`define RSP_SP_LOW_RESET 16'hf830
`define RSP_LOCAL_SP_RESET 16'h0000

// loop current in microamps
`define RSP_LOOP_LO_UA 16'h0fa0
`define RSP_LOOP_HI_UA 16'h4e20
`define RSP_LOOP_SPAN_UA 32'h00003e80
`define RSP_ERR_LO_UA 16'h0c80
`define RSP_ERR_HI_UA 16'h5140

`endif

/* File: rtl/rsp_scaler.v */
`timescale 1ns/1ps
`include "rsp_consts.vh"

module rsp_scaler (
   input wire clock,
   input wire rst,
   input wire [15:0] loop_ua,
   input wire signed [15:0] low_limit,
   input wire signed [15:0] high_limit,
   output reg signed [15:0] remote_sp_ff
);
   reg [15:0] clamped;
   reg signed [16:0] offset;
   reg signed [16:0] span;
   reg signed [33:0] product;
   reg signed [33:0] scaled;
   reg signed [15:0] nxt_remote_sp;

   always @* begin
      if (loop_ua < `RSP_LOOP_LO_UA) begin
         clamped = `RSP_LOOP_LO_UA;
      end else if (loop_ua > `RSP_LOOP_HI_UA) begin
         clamped = `RSP_LOOP_HI_UA;
      end else begin
         clamped = loop_ua;
      end
      offset = $signed({1'b0, clamped - `RSP_LOOP_LO_UA});
      span = {high_limit[15], high_limit} - {low_limit[15], low_limit};
      product = offset * span;
      // linear between the two limits
      scaled = product / $signed({2'b00, `RSP_LOOP_SPAN_UA});
      nxt_remote_sp = low_limit + scaled[15:0];
   end

   always @(posedge clock) begin
      if (rst) begin
         remote_sp_ff <= 16'sh0000;
      end else begin
         remote_sp_ff <= nxt_remote_sp;
      end
   end
endmodule // rsp_scaler

/* File: rtl/rsp_top.v */
`timescale 1ns/1ps
`include "rsp_consts.vh"

module rsp_top (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:0] loop_ua,
   input wire alarm1_src,
   input wire heater_alarm,
   input wire pv_input_error,
   output reg [15:0] set_point,
   output reg alarm1_out,
   output reg irq
);
   localparam ST_IDLE = 2'b01;
   localparam ST_ACCESS = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [`RSP_CTRL_WIDTH-1:0] ctrl_ff;
   reg [`RSP_CTRL_WIDTH-1:0] nxt_ctrl;
   reg signed [15:0] sp_high_ff;
   reg signed [15:0] nxt_sp_high;
   reg signed [15:0] sp_low_ff;
   reg signed [15:0] nxt_sp_low;
   reg signed [15:0] rsp_high_ff;
   reg signed [15:0] nxt_rsp_high;
   reg signed [15:0] rsp_low_ff;
   reg signed [15:0] nxt_rsp_low;
   reg signed [15:0] local_sp_ff;
   reg signed [15:0] nxt_local_sp;
   reg [`RSP_IRQ_WIDTH-1:0] stat_ff;
   reg [`RSP_IRQ_WIDTH-1:0] nxt_stat;
   reg [`RSP_IRQ_WIDTH-1:0] mask_ff;
   reg [`RSP_IRQ_WIDTH-1:0] nxt_mask;
   reg input_err_ff;
   reg [31:0] nxt_prdata;
   reg nxt_pslverr;
   reg [`RSP_IRQ_WIDTH-1:0] events;
   reg signed [15:0] active_sp;

   wire signed [15:0] remote_sp;
   wire signed [15:0] wval;
   wire commit;
   wire respond;
   wire sel;
   wire remote_active;
   wire limits_open;
   wire fault_allowed;
   wire input_err;

   assign wval = pwdata[15:0];
   // answer one cycle into the access phase, commit when pready is seen
   assign respond = (state_ff == ST_ACCESS) && psel && penable && !pready;
   assign commit = (state_ff == ST_ACCESS) && psel && penable && pready;
   assign sel = respond || commit;
   assign limits_open = ctrl_ff[`RSP_CTRL_ALLOW] && !ctrl_ff[`RSP_CTRL_SELF_TUNE];
   assign remote_active = limits_open && ctrl_ff[`RSP_CTRL_REMOTE_MODE];
   assign fault_allowed = ctrl_ff[`RSP_CTRL_FAULT_OUT] && limits_open &&
      !ctrl_ff[`RSP_CTRL_ALM1_WORK_BIT];
   assign input_err = (loop_ua < `RSP_ERR_LO_UA) || (loop_ua > `RSP_ERR_HI_UA);

   function in_range;
      input signed [15:0] v;
      input signed [15:0] lo;
      input signed [15:0] hi;
      begin
         in_range = (v >= lo) && (v <= hi);
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a <= `RSP_OFS_ALARM);
      end
   endfunction

   rsp_scaler u_scaler (
      .clock(clock),
      .rst(rst),
      .loop_ua(loop_ua),
      .low_limit(rsp_low_ff),
      .high_limit(rsp_high_ff),
      .remote_sp_ff(remote_sp)
   );

   always @* begin
      if (remote_active) begin
         active_sp = remote_sp;
      end else begin
         active_sp = local_sp_ff;
      end
   end

   // apb handshake: setup, one wait cycle, then pready
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (psel && !penable) begin
               nxt_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (commit) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @* begin
      nxt_ctrl = ctrl_ff;
      nxt_sp_high = sp_high_ff;
      nxt_sp_low = sp_low_ff;
      nxt_rsp_high = rsp_high_ff;
      nxt_rsp_low = rsp_low_ff;
      nxt_local_sp = local_sp_ff;
      nxt_mask = mask_ff;
      nxt_pslverr = 1'b0;
      events = {`RSP_IRQ_WIDTH{1'b0}};
      events[`RSP_IRQ_INPUT_ERR] = input_err && !input_err_ff;
      nxt_stat = stat_ff;
      if (sel && !mapped(paddr)) begin
         nxt_pslverr = 1'b1;
      end else if (sel && pwrite) begin
         case (paddr)
            `RSP_OFS_CTRL: begin
               nxt_ctrl = pwdata[`RSP_CTRL_WIDTH-1:0];
               if (remote_active && !pwdata[`RSP_CTRL_REMOTE_MODE]) begin
                  events[`RSP_IRQ_TO_LOCAL] = 1'b1;
                  if (ctrl_ff[`RSP_CTRL_FOLLOW]) begin
                     nxt_local_sp = remote_sp;
                  end
                  // tracking off keeps local_sp_ff as stored
               end
            end
            `RSP_OFS_SP_HIGH: begin
               if (wval >= sp_low_ff) begin
                  nxt_sp_high = wval;
                  nxt_rsp_high = wval;
                  events[`RSP_IRQ_LIMIT_FORCED] = 1'b1;
                  if (rsp_low_ff > wval) begin
                     nxt_rsp_low = wval;
                  end
               end else begin
                  nxt_pslverr = 1'b1;
               end
            end
            `RSP_OFS_SP_LOW: begin
               if (wval <= sp_high_ff) begin
                  nxt_sp_low = wval;
                  nxt_rsp_low = wval;
                  events[`RSP_IRQ_LIMIT_FORCED] = 1'b1;
                  if (rsp_high_ff < wval) begin
                     nxt_rsp_high = wval;
                  end
               end else begin
                  nxt_pslverr = 1'b1;
               end
            end
            `RSP_OFS_RSP_HIGH: begin
               if (limits_open && in_range(wval, sp_low_ff, sp_high_ff)) begin
                  nxt_rsp_high = wval;
               end else begin
                  nxt_pslverr = 1'b1;
               end
            end
            `RSP_OFS_RSP_LOW: begin
               if (limits_open && in_range(wval, sp_low_ff, sp_high_ff)) begin
                  nxt_rsp_low = wval;
               end else begin
                  nxt_pslverr = 1'b1;
               end
            end
            `RSP_OFS_LOCAL_SP: begin
               if (in_range(wval, sp_low_ff, sp_high_ff)) begin
                  nxt_local_sp = wval;
               end else begin
                  nxt_pslverr = 1'b1;
               end
            end
            `RSP_OFS_IRQ_STAT: begin
               nxt_stat = stat_ff & ~pwdata[`RSP_IRQ_WIDTH-1:0];
            end
            `RSP_OFS_IRQ_MASK: begin
               nxt_mask = pwdata[`RSP_IRQ_WIDTH-1:0];
            end
            default: begin
               // read-only registers ignore writes
               nxt_pslverr = 1'b0;
            end
         endcase
      end
      // response cycle only judges the write, nothing lands yet
      if (!commit) begin
         nxt_ctrl = ctrl_ff;
         nxt_sp_high = sp_high_ff;
         nxt_sp_low = sp_low_ff;
         nxt_rsp_high = rsp_high_ff;
         nxt_rsp_low = rsp_low_ff;
         nxt_local_sp = local_sp_ff;
         nxt_mask = mask_ff;
         nxt_stat = stat_ff;
         events[`RSP_IRQ_TO_LOCAL] = 1'b0;
         events[`RSP_IRQ_LIMIT_FORCED] = 1'b0;
      end
      // new events win over a same-cycle clear
      nxt_stat = nxt_stat | events;
   end

   always @* begin
      nxt_prdata = 32'h00000000;
      if (respond && !pwrite) begin
         case (paddr)
            `RSP_OFS_CTRL: nxt_prdata = {25'h0000000, ctrl_ff};
            `RSP_OFS_SP_HIGH: nxt_prdata = {16'h0000, sp_high_ff};
            `RSP_OFS_SP_LOW: nxt_prdata = {16'h0000, sp_low_ff};
            `RSP_OFS_RSP_HIGH: nxt_prdata = {16'h0000, rsp_high_ff};
            `RSP_OFS_RSP_LOW: nxt_prdata = {16'h0000, rsp_low_ff};
            `RSP_OFS_LOCAL_SP: nxt_prdata = {16'h0000, local_sp_ff};
            `RSP_OFS_REMOTE_SP: nxt_prdata = {16'h0000, remote_sp};
            `RSP_OFS_ACTIVE_SP: nxt_prdata = {16'h0000, active_sp};
            `RSP_OFS_LOOP_IN: nxt_prdata = {15'h0000, input_err_ff, loop_ua};
            `RSP_OFS_IRQ_STAT: nxt_prdata = {29'h00000000, stat_ff};
            `RSP_OFS_IRQ_MASK: nxt_prdata = {29'h00000000, mask_ff};
            `RSP_OFS_ALARM: nxt_prdata = {28'h0000000, alarm1_src, heater_alarm,
               pv_input_error, input_err_ff};
            default: nxt_prdata = 32'h00000000;
         endcase
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         ctrl_ff <= `RSP_CTRL_RESET;
         sp_high_ff <= `RSP_SP_HIGH_RESET;
         sp_low_ff <= `RSP_SP_LOW_RESET;
         rsp_high_ff <= `RSP_SP_HIGH_RESET;
         rsp_low_ff <= `RSP_SP_LOW_RESET;
         local_sp_ff <= `RSP_LOCAL_SP_RESET;
         stat_ff <= {`RSP_IRQ_WIDTH{1'b0}};
         mask_ff <= {`RSP_IRQ_WIDTH{1'b0}};
         input_err_ff <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         set_point <= `RSP_LOCAL_SP_RESET;
         alarm1_out <= 1'b0;
         irq <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ctrl_ff <= nxt_ctrl;
         sp_high_ff <= nxt_sp_high;
         sp_low_ff <= nxt_sp_low;
         rsp_high_ff <= nxt_rsp_high;
         rsp_low_ff <= nxt_rsp_low;
         local_sp_ff <= nxt_local_sp;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         input_err_ff <= input_err;
         prdata <= nxt_prdata;
         pready <= respond;
         pslverr <= respond && nxt_pslverr;
         set_point <= active_sp;
         // remote error joins the alarm only when the option is usable
         alarm1_out <= alarm1_src | heater_alarm | pv_input_error |
            (input_err_ff & fault_allowed &
            !ctrl_ff[`RSP_CTRL_SETTING_LVL]);
         irq <= |(nxt_stat & nxt_mask);
      end
   end
endmodule // rsp_top

/* File: verif/rsp_chk.sv */
`timescale 1ns/1ps
module rsp_chk (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [15:0] loop_ua,
   input wire alarm1_src,
   input wire heater_alarm,
   input wire pv_input_error,
   input wire [15:0] set_point,
   input wire alarm1_out,
   input wire irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire ua_ok = loop_ua >= 16'h0c80 && loop_ua <= 16'h5140;
   wire setup = psel && !penable;
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_ready_wait: assert property (setup |=> !pready ##1 pready) else $error("bad wait");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
   a_unmapped_err: assert property (setup && (paddr > 8'h2c || paddr[1:0] != 2'b00)
      |-> ##2 (pready && pslverr)) else $error("no error on unmapped");
   a_read_ok: assert property (setup && !pwrite && paddr <= 8'h2c && paddr[1:0] == 2'b00
      |-> ##2 (pready && !pslverr)) else $error("error on read");
   a_alarm_or: assert property (
      (alarm1_src || heater_alarm || pv_input_error) |=> alarm1_out) else $error("alarm lost");
   a_alarm_quiet: assert property (
      (!alarm1_src && !heater_alarm && !pv_input_error && ua_ok) [*2] |=> !alarm1_out)
      else $error("spurious alarm");
   a_reset_clean: assert property ($past(rst) |-> set_point == 16'h0 && !alarm1_out
      && !irq && !pready) else $error("outputs after reset");
endmodule // rsp_chk

/* File: verif/rsp_loop_src.sv */
`timescale 1ns/1ps
module rsp_loop_src (
   input wire clock,
   input wire [15:0] target,
   input wire slow,
   output logic [15:0] loop_ua
);
   // slow mode slews 500 uA a cycle like a sluggish transmitter
   always @(posedge clock) begin
      if (!slow) loop_ua <= target;
      else if (target > loop_ua + 16'h01f4) loop_ua <= loop_ua + 16'h01f4;
      else if (target + 16'h01f4 < loop_ua) loop_ua <= loop_ua - 16'h01f4;
      else loop_ua <= target;
   end
endmodule // rsp_loop_src

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "rsp_consts.vh"
module tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, erv, alarm1_out, irq;
   logic [2:0] srcs = 3'b000;
   logic [15:0] loop_ua, set_point, target = 16'h2ee0;
   logic [7:0] ctl [5] = '{8'h15, 8'h35, 8'h55, 8'h11, 8'h05};
   logic exp_al [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   int err_count = 0, compares = 0;
   always #50 clock = ~clock;
   rsp_loop_src src (.clock(clock), .target(target), .slow(slow), .loop_ua(loop_ua));
   rsp_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .loop_ua(loop_ua), .alarm1_src(srcs[2]), .heater_alarm(srcs[1]),
      .pv_input_error(srcs[0]), .set_point(set_point), .alarm1_out(alarm1_out), .irq(irq));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task conclude;
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) err_count++;
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk($sformatf("write error %h", a), {31'h0, erv}, {31'h0, e});
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("read %h", a), rdv, e);
   endtask
   task settle;
      repeat (4) @(posedge clock);
   endtask
   task sp(input logic [15:0] ua, input logic s, input logic [15:0] e);
      @(posedge clock);
      target <= ua;
      slow <= s;
      repeat (40) @(posedge clock);
      chk("set_point", {16'h0, set_point}, {16'h0, e});
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rd(`RSP_OFS_CTRL, 32'h0);
      rd(`RSP_OFS_RSP_HIGH, 32'h32c8);
      rd(`RSP_OFS_RSP_LOW, 32'hf830);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", {31'h0, erv}, 32'h1);
      wr(`RSP_OFS_CTRL, 32'h11, 1'b0);
      sp(16'h4e20, 1'b0, 16'h32c8);
      sp(16'h0fa0, 1'b0, 16'hf830);
      sp(16'h2ee0, 1'b0, 16'h157c);
      rd(`RSP_OFS_REMOTE_SP, 32'h157c);
      wr(`RSP_OFS_RSP_HIGH, 32'h36b0, 1'b1);
      wr(`RSP_OFS_RSP_HIGH, 32'h1388, 1'b0);
      sp(16'h4e20, 1'b1, 16'h1388);
      wr(`RSP_OFS_SP_HIGH, 32'h03e8, 1'b0);
      rd(`RSP_OFS_RSP_HIGH, 32'h03e8);
      sp(16'h4e20, 1'b0, 16'h03e8);
      wr(`RSP_OFS_IRQ_MASK, 32'h4, 1'b0);
      settle;
      chk("irq", {31'h0, irq}, 32'h1);
      wr(`RSP_OFS_IRQ_STAT, 32'h4, 1'b0);
      settle;
      chk("irq", {31'h0, irq}, 32'h0);
      wr(`RSP_OFS_LOCAL_SP, 32'h64, 1'b0);
      wr(`RSP_OFS_CTRL, 32'h19, 1'b0);
      wr(`RSP_OFS_RSP_LOW, 32'h0, 1'b1);
      wr(`RSP_OFS_CTRL, 32'h10, 1'b0);
      wr(`RSP_OFS_RSP_LOW, 32'h0, 1'b1);
      sp(16'h4e20, 1'b0, 16'h0064);
      wr(`RSP_OFS_CTRL, 32'h13, 1'b0);
      wr(`RSP_OFS_CTRL, 32'h03, 1'b0);
      rd(`RSP_OFS_LOCAL_SP, 32'h03e8);
      wr(`RSP_OFS_LOCAL_SP, 32'h64, 1'b0);
      wr(`RSP_OFS_CTRL, 32'h11, 1'b0);
      wr(`RSP_OFS_CTRL, 32'h01, 1'b0);
      rd(`RSP_OFS_LOCAL_SP, 32'h64);
      sp(16'h0bb8, 1'b0, 16'h0064);
      for (int i = 0; i < 5; i++) begin
         wr(`RSP_OFS_CTRL, {24'h0, ctl[i]}, 1'b0);
         settle;
         chk("alarm1_out", {31'h0, alarm1_out}, {31'h0, exp_al[i]});
      end
      wr(`RSP_OFS_IRQ_MASK, 32'h1, 1'b0);
      settle;
      chk("irq", {31'h0, irq}, 32'h1);
      wr(`RSP_OFS_IRQ_STAT, 32'h7, 1'b0);
      settle;
      chk("irq", {31'h0, irq}, 32'h0);
      sp(16'h2ee0, 1'b0, 16'h0064);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         srcs <= 3'b001 << i;
         settle;
         chk("alarm1_out", {31'h0, alarm1_out}, 32'h1);
      end
      conclude;
   end
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      conclude;
   end
endmodule // tb_top
bind rsp_top rsp_chk chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .loop_ua(loop_ua), .alarm1_src(alarm1_src), .heater_alarm(heater_alarm),
   .pv_input_error(pv_input_error), .set_point(set_point), .alarm1_out(alarm1_out),
   .irq(irq));
